// ---- core/exc_pkg.sv ----
// constants of the exception unit: register map, field positions, codes
// assumes a 32-bit register bus with one aligned word per register
package exc_pkg;
   // register byte offsets
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] CAUSE_OFS = 8'h04;
   localparam logic [7:0] EPC_LO_OFS = 8'h08;
   localparam logic [7:0] EPC_HI_OFS = 8'h0c;
   localparam logic [7:0] COUNT_OFS = 8'h10;
   localparam logic [7:0] COMPARE_OFS = 8'h14;
   localparam logic [7:0] WATCH_LO_OFS = 8'h18;
   localparam logic [7:0] WATCH_HI_OFS = 8'h1c;
   localparam logic [7:0] PERF0_OFS = 8'h20;
   localparam logic [7:0] PERF1_OFS = 8'h24;
   // status word fields
   localparam int ST_IE = 0;
   localparam int ST_EXL = 1;
   localparam int ST_ERL = 2;
   localparam int ST_KSU_LO = 3;
   localparam int ST_UX = 5;
   localparam int ST_SX = 6;
   localparam int ST_KX = 7;
   localparam int ST_IM_LO = 8;
   localparam int ST_ISA4 = 24;
   localparam int ST_CU_LO = 28;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0004;
   localparam logic [31:0] STATUS_WMASK = 32'hf100_ffff;
   // cause word fields
   localparam int CA_CODE_LO = 2;
   localparam int CA_IP_LO = 8;
   localparam int CA_CE_LO = 28;
   localparam int CA_BD = 31;
   // watch and performance fields
   localparam int WL_STORE = 0;
   localparam int WL_LOAD = 1;
   localparam int WATCH_LSB = 3;
   localparam int PERF_OVF_BIT = 31;
   localparam logic [1:0] KSU_KERNEL = 2'h0;
   localparam logic [1:0] KSU_SUPER = 2'h1;
   localparam logic [1:0] KSU_USER = 2'h2;
   // opcodes
   localparam logic [5:0] OP_FUNCTION_CODED_OPCODE_GROUP = 6'h00;
   localparam logic [5:0] OP_REG_IMMEDIATE_OPCODE_GROUP = 6'h01;
   localparam logic [5:0] OP_INDEXED_FLOAT_COPROC_INSTR = 6'h13;
   localparam logic [3:0] OP_COP_HI = 4'h4;
   localparam logic [1:0] OP_CPMEM_HI = 2'h3;
   localparam logic [5:0] FN_SYSCALL = 6'h0c;
   localparam logic [5:0] FN_BREAK = 6'h0d;
   typedef enum logic [4:0] {
      EC_INT = 5'h00, EC_TLBL = 5'h02, EC_TLBS = 5'h03, EC_SYS = 5'h08,
      EC_BP = 5'h09, EC_RI = 5'h0a, EC_CPU = 5'h0b, EC_TR = 5'h0d,
      EC_FPE = 5'h0f, EC_WATCH = 5'h17
   } exc_code_type;
   typedef enum logic {VEC_COMMON = 1'b0, VEC_REFILL = 1'b1} vec_type;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00, BUS_WRITE = 2'b01, BUS_RDWAIT = 2'b10
   } bus_state_type;
endpackage

// ---- core/exc_req_if.sv ----
// carrier between the exception unit and its decode and interrupt helpers
// assumes all parties share one clock; every signal is combinational
`timescale 1ns/10ps
interface exc_req_if;
   logic [31:0] instr;
   logic [1:0] ksu;
   logic [3:0] cu;
   logic isa4;
   logic ux;
   logic sx;
   logic dword_op;
   logic ri;
   logic cpu;
   logic [1:0] cpu_num;
   logic [7:0] ip;
   logic [7:0] im;
   logic ie;
   logic exception_level_bit;
   logic error_level_bit;
   logic irq_req;
   modport chk (input instr, ksu, cu, isa4, ux, sx, dword_op, output ri, cpu, cpu_num);
   modport gate (input ip, im, ie, exception_level_bit, error_level_bit, output irq_req);
   modport top (output instr, ksu, cu, isa4, ux, sx, dword_op, ip, im, ie, exception_level_bit, error_level_bit,
      input ri, cpu, cpu_num, irq_req);
endinterface

// ---- core/exc_unit.sv ----
// exception detection and recording unit with an ahb-lite register slave
// assumes one core clock, a pipeline that offers one instruction per cycle
// and raw interrupt pins from outside the clock domain
// Notes on behaviour
// - true conditional trap raises trap code through the common vector
// - epc takes faulting pc, or branch pc with delay flag in a slot
// - syscall raises system-call code; delay flag follows the slot
// - break raises breakpoint code; epc and delay flag as usual
// - undefined primary opcode raises reserved-instruction code
// - undefined function field in the function-coded group is reserved
// - undefined sub-opcode in the register-immediate group is reserved
// - doubleword ops in narrow user or supervisor mode are reserved
// - indexed float instruction with extension disabled is reserved
// - coprocessor unusable for cp1/cp2 not usable, cp0 outside kernel
// - coprocessor-unusable records its code and the coprocessor number
// - float coprocessor request raises float code; software clears source
// - load/store hitting watch address raises watch; cache ops never do
// - watch hit that misses cacheable data cache still refills; else hold
// - watch under exception or error level is held until both clear
// - held watch is dropped on reset or on a watch-low write
// - eight lines masked singly and by global enable; interrupt code
// - pending field shows live requests at read time
// - pending bit 7 is timer match or either counter overflow
// - compare write clears timer; zero in bit 31 clears overflow
// - software sets and clears pending bits 1:0; taken imprecisely
// - cold and soft reset clear external pending bits 2 to 6
// - refill vector only with exception level clear, else common
`timescale 1ns/10ps
module exc_unit (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // instruction at the exception point
   input wire logic INSTR_VALID,
   input wire logic [31:0] INSTR_WORD,
   input wire logic [63:0] INSTR_PC,
   input wire logic INSTR_IN_DELAY,
   input wire logic [63:0] BRANCH_PC,
   input wire logic TRAP_TRUE,
   input wire logic DWORD_OP,
   input wire logic TLB_REFILL,
   input wire logic TLB_STORE,
   input wire logic ERET,
   // memory reference of that instruction
   input wire logic MEM_LOAD,
   input wire logic MEM_STORE,
   input wire logic CACHE_OP,
   input wire logic [35:0] MEM_PADDR,
   input wire logic MEM_CACHEABLE,
   input wire logic DCACHE_MISS,
   // request sources
   input wire logic FPU_REQ,
   input wire logic [1:0] PERF_OVF,
   input wire logic [4:0] HW_IRQ,
   // exception entry
   output logic EXC_TAKE,
   output logic [4:0] EXC_CODE,
   output logic EXC_VEC,
   output logic WATCH_REFILL_OK,
   output logic WATCH_CACHE_HOLD
);
   exc_req_if req ();
   instr_check u_check (
      .req(req.chk)
   );
   irq_gate u_gate (
      .req(req.gate)
   );

   exc_pkg::bus_state_type bus_q;
   exc_pkg::bus_state_type bus_d;
   logic [7:0] addr_q;
   logic [31:0] rdata_q;
   logic ready_q;
   logic [31:0] status_q;
   logic [1:0] sw_ip_q;
   logic [4:0] code_q;
   logic bd_q;
   logic [1:0] ce_q;
   logic vec_q;
   logic take_q;
   logic [63:0] epc_q;
   logic [31:0] count_q;
   logic [31:0] compare_q;
   logic timer_q;
   logic [31:0] watch_lo_q;
   logic [3:0] watch_hi_q;
   logic watch_pend_q;
   logic [1:0] perf_ovf_q;
   logic [4:0] hw_s1_q;
   logic [4:0] hw_s2_q;
   logic refill_q;
   logic hold_q;

   // bus decode
   wire addr_ok = HSEL && HTRANS[1] && HREADY;
   wire wr_now = (bus_q == exc_pkg::BUS_WRITE);
   wire wr_status = wr_now && (addr_q == exc_pkg::STATUS_OFS);
   wire wr_cause = wr_now && (addr_q == exc_pkg::CAUSE_OFS);
   wire wr_count = wr_now && (addr_q == exc_pkg::COUNT_OFS);
   wire wr_compare = wr_now && (addr_q == exc_pkg::COMPARE_OFS);
   wire wr_wlo = wr_now && (addr_q == exc_pkg::WATCH_LO_OFS);
   wire wr_whi = wr_now && (addr_q == exc_pkg::WATCH_HI_OFS);
   wire [1:0] wr_perf = {wr_now && (addr_q == exc_pkg::PERF1_OFS),
      wr_now && (addr_q == exc_pkg::PERF0_OFS)};
   assign bus_d = addr_ok ? (HWRITE ? exc_pkg::BUS_WRITE : exc_pkg::BUS_RDWAIT)
      : exc_pkg::BUS_IDLE;

   // status fields
   wire exception_level_bit = status_q[exc_pkg::ST_EXL];
   wire error_level_bit = status_q[exc_pkg::ST_ERL];
   wire [1:0] ksu = status_q[exc_pkg::ST_KSU_LO +: 2];

   // pending field, live
   wire perf_any = |perf_ovf_q;
   wire ip7 = timer_q || perf_any;
   wire [7:0] ip = {ip7, hw_s2_q, sw_ip_q};

   assign req.instr = INSTR_WORD;
   assign req.ksu = ksu;
   assign req.cu = status_q[exc_pkg::ST_CU_LO +: 4];
   assign req.isa4 = status_q[exc_pkg::ST_ISA4];
   assign req.ux = status_q[exc_pkg::ST_UX];
   assign req.sx = status_q[exc_pkg::ST_SX];
   assign req.dword_op = DWORD_OP;
   assign req.ip = ip;
   assign req.im = status_q[exc_pkg::ST_IM_LO +: 8];
   assign req.ie = status_q[exc_pkg::ST_IE];
   assign req.exception_level_bit = exception_level_bit;
   assign req.error_level_bit = error_level_bit;

   // exception sources of the current instruction
   wire v = INSTR_VALID;
   wire [5:0] op = INSTR_WORD[31:26];
   wire [5:0] fn = INSTR_WORD[5:0];
   wire function_coded_opcode_group = (op == exc_pkg::OP_FUNCTION_CODED_OPCODE_GROUP);
   wire tlb = v && TLB_REFILL;
   wire cpu = v && req.cpu;
   wire ri = v && req.ri;
   wire sys = v && function_coded_opcode_group && (fn == exc_pkg::FN_SYSCALL);
   wire brk = v && function_coded_opcode_group && (fn == exc_pkg::FN_BREAK);
   wire trap = v && TRAP_TRUE;
   wire float_exc_code = v && FPU_REQ;
   wire [32:0] watch_addr = {watch_hi_q, watch_lo_q[31:exc_pkg::WATCH_LSB]};
   wire watch_kind = (MEM_LOAD && watch_lo_q[exc_pkg::WL_LOAD])
      || (MEM_STORE && watch_lo_q[exc_pkg::WL_STORE]);
   wire watch_hit = v && watch_kind && !CACHE_OP
      && (MEM_PADDR[35:exc_pkg::WATCH_LSB] == watch_addr);
   wire watch_now = watch_hit && !exception_level_bit && !error_level_bit;
   wire watch_defer = watch_hit && (exception_level_bit || error_level_bit);
   wire watch_late = v && watch_pend_q && !exception_level_bit && !error_level_bit;
   wire irq = v && req.irq_req;
   wire take = tlb || cpu || ri || sys || brk || trap || float_exc_code || watch_now || watch_late || irq;
   wire refill_fill = MEM_CACHEABLE && DCACHE_MISS;

   // fixed priority, one code per entry
   wire [4:0] code_sel = tlb ? (TLB_STORE ? exc_pkg::EC_TLBS : exc_pkg::EC_TLBL)
      : cpu ? exc_pkg::EC_CPU
      : ri ? exc_pkg::EC_RI
      : sys ? exc_pkg::EC_SYS
      : brk ? exc_pkg::EC_BP
      : trap ? exc_pkg::EC_TR
      : float_exc_code ? exc_pkg::EC_FPE
      : (watch_now || watch_late) ? exc_pkg::EC_WATCH
      : exc_pkg::EC_INT;
   wire vec_sel = (tlb && !exception_level_bit) ? exc_pkg::VEC_REFILL : exc_pkg::VEC_COMMON;
   wire [63:0] epc_sel = INSTR_IN_DELAY ? BRANCH_PC : INSTR_PC;
   // only a watch that wins the priority counts as taken
   wire watch_won = (code_sel == exc_pkg::EC_WATCH);

   // status: exception entry wins over software and return
   wire [31:0] status_sw = wr_status
      ? ((HWDATA & exc_pkg::STATUS_WMASK) | (status_q & ~exc_pkg::STATUS_WMASK))
      : status_q;
   wire exl_next = take ? 1'b1 : ((ERET && !error_level_bit) ? 1'b0 : status_sw[exc_pkg::ST_EXL]);
   wire erl_next = (ERET && error_level_bit) ? 1'b0 : status_sw[exc_pkg::ST_ERL];
   wire [31:0] status_next = {status_sw[31:exc_pkg::ST_ERL + 1], erl_next, exl_next,
      status_sw[exc_pkg::ST_IE]};

   // read mux
   wire [31:0] cause_word = (32'(bd_q) << exc_pkg::CA_BD) | (32'(ce_q) << exc_pkg::CA_CE_LO)
      | (32'(ip) << exc_pkg::CA_IP_LO) | (32'(code_q) << exc_pkg::CA_CODE_LO);
   wire [31:0] rd_word = (addr_q == exc_pkg::STATUS_OFS) ? status_q
      : (addr_q == exc_pkg::CAUSE_OFS) ? cause_word
      : (addr_q == exc_pkg::EPC_LO_OFS) ? epc_q[31:0]
      : (addr_q == exc_pkg::EPC_HI_OFS) ? epc_q[63:32]
      : (addr_q == exc_pkg::COUNT_OFS) ? count_q
      : (addr_q == exc_pkg::COMPARE_OFS) ? compare_q
      : (addr_q == exc_pkg::WATCH_LO_OFS) ? watch_lo_q
      : (addr_q == exc_pkg::WATCH_HI_OFS) ? {28'h000_0000, watch_hi_q}
      : (addr_q == exc_pkg::PERF0_OFS) ? (32'(perf_ovf_q[0]) << exc_pkg::PERF_OVF_BIT)
      : (addr_q == exc_pkg::PERF1_OFS) ? (32'(perf_ovf_q[1]) << exc_pkg::PERF_OVF_BIT)
      : 32'h0000_0000;

   // bus slave; reads take one wait state so a preceding write is seen
   always_ff @(posedge CLK) begin
      if (RESET) begin
         bus_q <= exc_pkg::BUS_IDLE;
         addr_q <= 8'h00;
         ready_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (bus_q != exc_pkg::BUS_RDWAIT) begin
            bus_q <= bus_d;
         end else begin
            bus_q <= exc_pkg::BUS_IDLE;
         end
         if (addr_ok) begin
            addr_q <= HADDR[7:0];
         end
         ready_q <= !(addr_ok && !HWRITE);
         if (bus_q == exc_pkg::BUS_RDWAIT) begin
            rdata_q <= rd_word;
         end
      end
   end

   // pin synchroniser; reset drops external requests
   always_ff @(posedge CLK) begin
      if (RESET) begin
         hw_s1_q <= 5'h00;
         hw_s2_q <= 5'h00;
      end else begin
         hw_s1_q <= HW_IRQ;
         hw_s2_q <= hw_s1_q;
      end
   end

   // status and cause
   always_ff @(posedge CLK) begin
      if (RESET) begin
         status_q <= exc_pkg::STATUS_RESET;
         sw_ip_q <= 2'h0;
         code_q <= 5'h00;
         bd_q <= 1'b0;
         ce_q <= 2'h0;
         epc_q <= 64'h0000_0000_0000_0000;
      end else begin
         status_q <= status_next;
         if (wr_cause) begin
            sw_ip_q <= HWDATA[exc_pkg::CA_IP_LO +: 2];
         end
         if (take) begin
            code_q <= code_sel;
            bd_q <= INSTR_IN_DELAY;
            ce_q <= cpu ? req.cpu_num : 2'h0;
            epc_q <= epc_sel;
         end
      end
   end

   // timer: set wins over the compare write
   always_ff @(posedge CLK) begin
      if (RESET) begin
         count_q <= 32'h0000_0000;
         compare_q <= 32'h0000_0000;
         timer_q <= 1'b0;
      end else begin
         count_q <= wr_count ? HWDATA : count_q + 32'h0000_0001;
         if (wr_compare) begin
            compare_q <= HWDATA;
         end
         if (count_q == compare_q) begin
            timer_q <= 1'b1;
         end else if (wr_compare) begin
            timer_q <= 1'b0;
         end
      end
   end

   // counter overflow requests
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_perf
         wire clr = wr_perf[g] && !HWDATA[exc_pkg::PERF_OVF_BIT];
         always_ff @(posedge CLK) begin
            if (RESET) begin
               perf_ovf_q[g] <= 1'b0;
            end else if (PERF_OVF[g]) begin
               perf_ovf_q[g] <= 1'b1;
            end else if (clr) begin
               perf_ovf_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // watch registers and the held watch
   always_ff @(posedge CLK) begin
      if (RESET) begin
         watch_lo_q <= 32'h0000_0000;
         watch_hi_q <= 4'h0;
         watch_pend_q <= 1'b0;
      end else begin
         if (wr_wlo) begin
            watch_lo_q <= HWDATA;
         end
         if (wr_whi) begin
            watch_hi_q <= HWDATA[3:0];
         end
         if (watch_defer) begin
            watch_pend_q <= 1'b1;
         end else if (wr_wlo || (watch_late && watch_won)) begin
            watch_pend_q <= 1'b0;
         end
      end
   end

   // entry outputs
   always_ff @(posedge CLK) begin
      if (RESET) begin
         take_q <= 1'b0;
         vec_q <= exc_pkg::VEC_COMMON;
         refill_q <= 1'b0;
         hold_q <= 1'b0;
      end else begin
         take_q <= take;
         vec_q <= vec_sel;
         refill_q <= watch_now && watch_won && refill_fill;
         hold_q <= watch_now && watch_won && !refill_fill;
      end
   end

   assign HRDATA = rdata_q;
   assign HREADYOUT = ready_q;
   assign HRESP = 1'b0;
   assign EXC_TAKE = take_q;
   assign EXC_CODE = code_q;
   assign EXC_VEC = vec_q;
   assign WATCH_REFILL_OK = refill_q;
   assign WATCH_CACHE_HOLD = hold_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   wire hi_pri = tlb || cpu || ri;

   trap_code_a: assert property (trap && !hi_pri && !sys && !brk
      |=> EXC_TAKE && EXC_CODE == exc_pkg::EC_TR)
      else $error("trap not recorded");
   delay_epc_a: assert property (take && INSTR_IN_DELAY
      |=> epc_q == $past(BRANCH_PC) && bd_q)
      else $error("delay slot epc wrong");
   sys_bd_a: assert property (sys && !hi_pri
      |=> EXC_CODE == exc_pkg::EC_SYS && bd_q == $past(INSTR_IN_DELAY))
      else $error("syscall entry wrong");
   brk_epc_a: assert property (brk && !hi_pri && !INSTR_IN_DELAY
      |=> EXC_CODE == exc_pkg::EC_BP && epc_q == $past(INSTR_PC))
      else $error("break entry wrong");
   cpu_num_a: assert property (cpu && !tlb
      |=> EXC_CODE == exc_pkg::EC_CPU && ce_q == $past(req.cpu_num))
      else $error("coprocessor number wrong");
   watch_hold_a: assert property (watch_defer |=> watch_pend_q && !hold_q)
      else $error("watch not held");
   watch_drop_a: assert property (wr_wlo && !watch_defer |=> !watch_pend_q)
      else $error("held watch kept");
   irq_gate_a: assert property (!status_q[exc_pkg::ST_IE] |-> !req.irq_req)
      else $error("interrupt passed disabled");
   timer_clr_a: assert property (wr_compare && count_q != compare_q ##1 count_q != compare_q
      |-> !timer_q)
      else $error("timer not cleared");
   ip_reset_a: assert property ($fell(RESET) |-> ip[6:2] == 5'h00)
      else $error("external pending survived reset");
   vec_sel_a: assert property (tlb && exception_level_bit |=> EXC_VEC == exc_pkg::VEC_COMMON)
      else $error("nested refill vector");
   prio_a: assert property (cpu && ri && !tlb |=> EXC_CODE == exc_pkg::EC_CPU)
      else $error("priority broken");

   irq_take_c: cover property (irq ##1 EXC_TAKE);
   watch_late_c: cover property (watch_defer ##[1:20] watch_late);
   read_c: cover property (bus_q == exc_pkg::BUS_RDWAIT ##1 HREADYOUT);
endmodule

// ---- core/instr_check.sv ----
// decode checks: reserved encodings and coprocessor usability
// assumes the instruction word and mode bits are stable in the cycle used
`timescale 1ns/10ps
module instr_check #(
   parameter logic [63:0] PRIMARY_OK = 64'hf7ff_ffff_0fff_ffff,
   parameter logic [63:0] FUNCTION_CODED_OPCODE_GROUP_OK = 64'hfff3_fff3_fff7_fffd,
   parameter logic [31:0] REG_IMMEDIATE_OPCODE_GROUP_OK = 32'h000f_7f0f
) (
   exc_req_if.chk req
);
   wire [5:0] op = req.instr[31:26];
   wire [5:0] fn = req.instr[5:0];
   wire [4:0] rt = req.instr[20:16];
   wire kernel = (req.ksu == exc_pkg::KSU_KERNEL);
   wire narrow = (req.ksu == exc_pkg::KSU_USER) ? !req.ux : !req.sx;
   wire cop_op = (op[5:2] == exc_pkg::OP_COP_HI);
   wire cop_mem = (op[5:4] == exc_pkg::OP_CPMEM_HI) && (op[1:0] != 2'h0) && (op[1:0] != 2'h3);
   wire indexed_float_coproc_instr = (op == exc_pkg::OP_INDEXED_FLOAT_COPROC_INSTR);
   wire [1:0] num = indexed_float_coproc_instr ? 2'h1 : op[1:0];
   // cp0 stays usable in kernel mode
   wire cu_ok = req.cu[num] || ((num == 2'h0) && kernel);
   wire op_bad = !PRIMARY_OK[op];
   wire fn_bad = (op == exc_pkg::OP_FUNCTION_CODED_OPCODE_GROUP) && !FUNCTION_CODED_OPCODE_GROUP_OK[fn];
   wire rt_bad = (op == exc_pkg::OP_REG_IMMEDIATE_OPCODE_GROUP) && !REG_IMMEDIATE_OPCODE_GROUP_OK[rt];
   wire dword_bad = req.dword_op && !kernel && narrow;
   wire x_bad = indexed_float_coproc_instr && !req.isa4;
   assign req.ri = op_bad || fn_bad || rt_bad || dword_bad || x_bad;
   assign req.cpu = (cop_op || cop_mem) && !cu_ok;
   assign req.cpu_num = num;
endmodule

// ---- core/irq_gate.sv ----
// interrupt gating: per-line mask, global enable, exception levels
// assumes the pending field is already synchronised to the core clock
`timescale 1ns/10ps
module irq_gate (
   exc_req_if.gate req
);
   wire [7:0] live = req.ip & req.im;
   assign req.irq_req = (|live) && req.ie && !req.exception_level_bit && !req.error_level_bit;
endmodule

// ---- testbench/pipe_model.sv ----
// far-side model: pipeline at the exception point, float request, irq pins
// assumes one clock; the unit answers one cycle after an instruction
`timescale 1ns/10ps
module pipe_model (
   // clock
   input wire logic clk,
   // instruction and its memory reference
   output logic valid,
   output logic [31:0] word,
   output logic [63:0] pc,
   output logic [63:0] bpc,
   output logic [7:0] fl,
   output logic [35:0] addr,
   // request sources
   output logic fpu,
   output logic [1:0] ovf,
   output logic [4:0] irq,
   // answer of the unit
   input wire logic [8:0] ans
);
   initial begin
      valid = 1'b0;
      word = 32'h0;
      pc = 64'h0000_0a0b_0000_1000;
      bpc = 64'h0;
      fl = 8'h0;
      addr = 36'h0_1234_5678;
      fpu = 1'b0;
      ovf = 2'h0;
      irq = 5'h0;
   end
   // one instruction for one cycle, answer sampled a cycle later
   task automatic exec(input logic [31:0] w, input logic [7:0] f, output logic [8:0] r);
      @(posedge clk);
      valid <= 1'b1;
      word <= w;
      fl <= f;
      pc <= pc + 64'h4;
      bpc <= pc;
      @(posedge clk);
      valid <= 1'b0;
      // idle word never repeats the last one
      word <= ~w;
      fl <= 8'h0;
      #1 r = ans;
   endtask
endmodule

// ---- testbench/test_cpu_exception_interrupt_unit.sv ----
// self-checking bench of the exception unit driven by a pipeline model
// assumes the unit, its package, interface and helpers are compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module test_cpu_exception_interrupt_unit;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rdat;
   logic hreadyout, valid, fpu;
   logic [31:0] word;
   logic [63:0] pc, bpc;
   logic [7:0] fl;
   logic [35:0] addr;
   logic [1:0] ovf;
   logic [4:0] irq;
   logic [8:0] ans;
   int n_errors = 0;
   int num_checks = 0;
   // status, word, flags, expected {take, vec, refill, hold, code}
   localparam logic [80:0] CASES [0:19] = '{
      {32'h0, 32'h0, 8'h02, 9'h10d},
      {32'h0, 32'h0000_000c, 8'h01, 9'h108},
      {32'h0, 32'h0000_000d, 8'h00, 9'h109},
      {32'h0, 32'h7000_0000, 8'h00, 9'h10a},
      {32'h0, 32'h0000_0001, 8'h00, 9'h10a},
      {32'h0, 32'h0404_0000, 8'h00, 9'h10a},
      {32'h10, 32'h0, 8'h04, 9'h10a},
      {32'h0, 32'h0, 8'h04, 9'h000},
      {32'hf000_0000, 32'h4c00_0000, 8'h00, 9'h10a},
      {32'h0, 32'h4800_0000, 8'h00, 9'h10b},
      {32'h0, 32'h4000_0000, 8'h00, 9'h000},
      {32'h10, 32'h4000_0000, 8'h00, 9'h10b},
      {32'h0, 32'h0, 8'h08, 9'h182},
      {32'h2, 32'h0, 8'h08, 9'h102},
      {32'h0, 32'h0000_000c, 8'h02, 9'h108},
      {32'h10, 32'h4800_0000, 8'h04, 9'h10b},
      {32'h0, 32'h0, 8'h90, 9'h157},
      {32'h0, 32'h0, 8'h10, 9'h137},
      {32'h0, 32'h0, 8'h50, 9'h000},
      {32'h0, 32'h0, 8'h20, 9'h000}
   };
   always #2.5 clk = ~clk;
   exc_unit exc_unit_i (
      .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(), .INSTR_VALID(valid), .INSTR_WORD(word), .INSTR_PC(pc),
      .INSTR_IN_DELAY(fl[0]), .BRANCH_PC(bpc), .TRAP_TRUE(fl[1]), .DWORD_OP(fl[2]),
      .TLB_REFILL(fl[3]), .TLB_STORE(1'b0), .ERET(1'b0), .MEM_LOAD(fl[4]), .MEM_STORE(fl[5]),
      .CACHE_OP(fl[6]), .MEM_PADDR(addr), .MEM_CACHEABLE(fl[7]), .DCACHE_MISS(fl[7]),
      .FPU_REQ(fpu), .PERF_OVF(ovf), .HW_IRQ(irq), .EXC_TAKE(ans[8]), .EXC_VEC(ans[7]),
      .WATCH_REFILL_OK(ans[6]), .WATCH_CACHE_HOLD(ans[5]), .EXC_CODE(ans[4:0])
   );
   pipe_model pipe_model_i (
      .clk(clk), .valid(valid), .word(word), .pc(pc), .bpc(bpc), .fl(fl), .addr(addr),
      .fpu(fpu), .ovf(ovf), .irq(irq), .ans(ans)
   );
   // one single word transfer; read data lands in rdat
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= v;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rdat = hrdata;
   endtask
   task automatic run(input logic [31:0] st, input logic [31:0] w, input logic [7:0] f,
      input logic [8:0] e);
      logic [8:0] r;
      logic [63:0] exception_return_pc;
      bus(1'b1, exc_pkg::STATUS_OFS, st);
      pipe_model_i.exec(w, f, r);
      exception_return_pc = f[0] ? bpc : pc;
      if (e[8]) begin
         `CHK(r, e)
         bus(1'b0, exc_pkg::EPC_LO_OFS, 32'h0);
         `CHK(rdat, exception_return_pc[31:0])
         bus(1'b0, exc_pkg::EPC_HI_OFS, 32'h0);
         `CHK(rdat, exception_return_pc[63:32])
         bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
         `CHK({rdat[31], rdat[29:28], rdat[6:2]}, {f[0], (e[4:0] == 5'h0b) ? w[27:26] : 2'h0, e[4:0]})
      end else begin
         `CHK(r[8:5], 4'h0)
      end
   endtask
   task automatic t_reset();
      bus(1'b0, exc_pkg::STATUS_OFS, 32'h0);
      `CHK(rdat, 32'h0000_0004)
      bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
      `CHK(rdat[14:8], 7'h00)
      // count and compare both start at zero, so the timer request is up
      `CHK(rdat[15], 1'b1)
      bus(1'b0, 8'h40, 32'h0);
      `CHK(rdat, 32'h0)
      bus(1'b1, exc_pkg::COMPARE_OFS, 32'h8000_0000);
      bus(1'b1, exc_pkg::WATCH_HI_OFS, 32'h0);
      bus(1'b1, exc_pkg::WATCH_LO_OFS, 32'h1234_567a);
   endtask
   task automatic t_held();
      logic [8:0] r;
      bus(1'b1, exc_pkg::STATUS_OFS, 32'h2);
      pipe_model_i.exec(32'h0, 8'h10, r);
      `CHK(r[8], 1'b0)
      bus(1'b1, exc_pkg::STATUS_OFS, 32'h0);
      pipe_model_i.exec(32'h0, 8'h00, r);
      `CHK({r[8], r[4:0]}, 6'h37)
      bus(1'b0, exc_pkg::EPC_LO_OFS, 32'h0);
      `CHK(rdat, pc[31:0])
      bus(1'b1, exc_pkg::STATUS_OFS, 32'h2);
      pipe_model_i.exec(32'h0, 8'h10, r);
      bus(1'b1, exc_pkg::WATCH_LO_OFS, 32'h1234_567a);
      bus(1'b1, exc_pkg::STATUS_OFS, 32'h0);
      pipe_model_i.exec(32'h0, 8'h00, r);
      `CHK(r[8], 1'b0)
   endtask
   task automatic t_irq();
      pipe_model_i.irq <= 5'h01;
      repeat (4) @(posedge clk);
      bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
      `CHK(rdat[15:8], 8'h04)
      run(32'h0000_0401, 32'h0, 8'h00, 9'h100);
      run(32'h0000_fb01, 32'h0, 8'h00, 9'h000);
      run(32'h0000_0400, 32'h0, 8'h00, 9'h000);
      pipe_model_i.irq <= 5'h00;
      pipe_model_i.fpu <= 1'b1;
      run(32'h0, 32'h0, 8'h00, 9'h10f);
      // software clears the float source after entry
      pipe_model_i.fpu <= 1'b0;
      bus(1'b0, exc_pkg::COUNT_OFS, 32'h0);
      bus(1'b1, exc_pkg::COMPARE_OFS, rdat + 32'h40);
      repeat (80) @(posedge clk);
      bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
      `CHK(rdat[15], 1'b1)
      pipe_model_i.ovf <= 2'h2;
      @(posedge clk);
      pipe_model_i.ovf <= 2'h0;
      bus(1'b1, exc_pkg::COMPARE_OFS, 32'h8000_0000);
      bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
      `CHK(rdat[15], 1'b1)
      bus(1'b1, exc_pkg::PERF1_OFS, 32'h0);
      bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
      `CHK(rdat[15:8], 8'h00)
      bus(1'b1, exc_pkg::CAUSE_OFS, 32'h0000_0300);
      bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
      `CHK(rdat[15:8], 8'h03)
      bus(1'b1, exc_pkg::CAUSE_OFS, 32'h0000_0100);
      bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
      `CHK(rdat[15:8], 8'h01)
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      foreach (CASES[i]) run(CASES[i][80:49], CASES[i][48:17], CASES[i][16:9], CASES[i][8:0]);
      t_held();
      t_irq();
      end_of_test();
   end
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #50000;
      n_errors++;
      end_of_test();
   end
endmodule
